// file: include/timer_wdt_pkg.sv
/*
  Shared constants and types for the dual timer and watchdog block:
  register addresses, field positions, reset values, mode codes and
  the packed control records of a timer channel and of the watchdog.
  Assumes nothing of its surroundings; it is compiled before the design.
*/
package timer_wdt_pkg;

  // Register byte addresses on the peripheral bus.
  localparam logic [31:0] ADDR_CTRL0 = 32'hfff81000;
  localparam logic [31:0] ADDR_CTRL1 = 32'hfff81004;
  localparam logic [31:0] ADDR_RELOAD0 = 32'hfff81008;
  localparam logic [31:0] ADDR_RELOAD1 = 32'hfff8100c;
  localparam logic [31:0] ADDR_COUNT0 = 32'hfff81010;
  localparam logic [31:0] ADDR_COUNT1 = 32'hfff81014;
  localparam logic [31:0] ADDR_FLAGS = 32'hfff81018;
  localparam logic [31:0] ADDR_WD_CTRL = 32'hfff8101c;

  // Reset values of the writable registers.
  localparam logic [31:0] CTRL_RESET = 32'h00000005;
  localparam logic [31:0] WD_CTRL_RESET = 32'h00000400;

  // Channel control and status field positions.
  localparam int CH_OVERRIDE_BIT = 31;
  localparam int CH_ENABLE_BIT = 30;
  localparam int CH_IRQ_EN_BIT = 29;
  localparam int CH_MODE_MSB = 28;
  localparam int CH_MODE_LSB = 27;
  localparam int CH_CLEAR_BIT = 26;
  localparam int CH_ACTIVE_BIT = 25;
  localparam int CH_PRESCALE_MSB = 7;
  localparam int COUNT_MSB = 23;

  // Watchdog control field positions.
  localparam int WD_DIVIDE_BIT = 10;
  localparam int WD_OVERRIDE_BIT = 9;
  localparam int WD_TEST_BIT = 8;
  localparam int WD_ENABLE_BIT = 7;
  localparam int WD_IRQ_EN_BIT = 6;
  localparam int WD_SELECT_MSB = 5;
  localparam int WD_SELECT_LSB = 4;
  localparam int WD_IRQ_FLAG_BIT = 3;
  localparam int WD_RESET_FLAG_BIT = 2;
  localparam int WD_RESET_EN_BIT = 1;
  localparam int WD_RESTART_BIT = 0;

  // Channel operating mode codes; the fourth code is reserved.
  localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
  localparam logic [1:0] MODE_PERIODIC = 2'h1;
  localparam logic [1:0] MODE_TOGGLE = 2'h2;

  // Watchdog counter geometry and timing counts in watchdog clocks.
  localparam int WD_WIDTH = 26;
  localparam int WD_HALF = 13;
  localparam logic [7:0] WD_DIVIDE_LAST = 8'hff;
  localparam logic [9:0] WD_RESET_DELAY_LAST = 10'h1ff;
  localparam logic [25:0] WD_LIMIT_SEL0 = 26'h0003fff;
  localparam logic [25:0] WD_LIMIT_SEL1 = 26'h000ffff;
  localparam logic [25:0] WD_LIMIT_SEL2 = 26'h003ffff;
  localparam logic [25:0] WD_LIMIT_SEL3 = 26'h00fffff;

  // Software-visible settings of one timer channel.
  typedef struct packed {
    logic debug_hold_override;
    logic count_enable;
    logic channel_irq_enable;
    logic [1:0] mode;
    logic [7:0] prescale;
  } chan_ctrl_type;

  // Software-visible settings of the watchdog.
  typedef struct packed {
    logic wd_clock_divide;
    logic debug_hold_override;
    logic wd_test_mode;
    logic wd_enable;
    logic wd_irq_enable;
    logic [1:0] wd_interval_select;
    logic wd_reset_enable;
  } wd_ctrl_type;

endpackage : timer_wdt_pkg

// file: src/dual_timer_and_watchdog.sv
/*
  Two 24-bit down-counting timer channels with 8-bit prescalers and a
  watchdog timer, all reached through a peripheral-bus register slave.
  Assumes a single 50 MHz clock, bus inputs and the crystal input that
  are synchronous to it, and timer_wdt_pkg compiled beforehand.
*/

// What this block does
// - Channel freezes on debug unless override set.
// - Channel counts only while count enable set.
// - Enabled channel interrupt asserts on reaching zero.
// - Modes: one-shot, periodic, toggle; code three reserved.
// - Writing counter clear zeroes counters and enable.
// - Read-only active bit shows channel running.
// - Prescaler divides by prescale value plus one.
// - Counter reloads initial count on reaching zero.
// - Writing initial count restarts from new value.
// - Current count readable; valid when stopped.
// - Per-channel flag sets when counter reaches zero.
// - Flags ignore plain writes; writing one clears.
// - Watchdog clock is crystal, optionally divided.
// - Watchdog freezes on debug unless override set.
// - Test mode splits watchdog into two halves.
// - Clearing watchdog enable stops and clears counter.
// - Interval select picks two to fourteen..twenty.
// - Missed restart raises watchdog interrupt if enabled.
// - Reset issued delay after timeout if enabled.
// - Watchdog reset sets sticky reset flag.
// - Writing restart clears watchdog counter; self-clearing.
// - Two channels, each prescaler, counter, interrupt.
module dual_timer_and_watchdog (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Peripheral register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  // Debug and crystal inputs.
  input wire logic debug_acknowledge_in,
  input wire logic xtal_in,
  // Timer outputs.
  output logic [1:0] timer_irq,
  output logic [1:0] timer_out,
  // Watchdog outputs.
  output logic wd_irq,
  output logic wd_system_reset
);

  // Decodes a write access to one register address.
  function automatic logic write_hit(input logic [31:0] addr);
    write_hit = psel && penable && pwrite && (paddr == addr);
  endfunction : write_hit

  // Bus access strobes.
  logic write_flags; // Write to the interrupt flag register.
  logic write_wd; // Write to the watchdog control register.
  logic [1:0] write_ctrl; // Write to a channel control register.
  logic [1:0] write_reload; // Write to a channel initial count register.

  // Per-channel state, one element per channel.
  timer_wdt_pkg::chan_ctrl_type ctrl [2]; // Channel settings.
  logic [7:0] presc [2]; // Prescale counter.
  logic [23:0] count [2]; // Current down count.
  logic [23:0] initial_count [2]; // Reload value.
  logic [1:0] flag; // Channel interrupt flags, bit per channel.
  logic [1:0] running; // Channel is counting this cycle.
  logic [1:0] expire; // Counter steps from one back to the reload value this cycle.

  // Write strobes decoded once, shared by every process.
  always_comb
  begin
    write_flags = write_hit(timer_wdt_pkg::ADDR_FLAGS);
    write_wd = write_hit(timer_wdt_pkg::ADDR_WD_CTRL);
    write_ctrl[0] = write_hit(timer_wdt_pkg::ADDR_CTRL0);
    write_ctrl[1] = write_hit(timer_wdt_pkg::ADDR_CTRL1);
    write_reload[0] = write_hit(timer_wdt_pkg::ADDR_RELOAD0);
    write_reload[1] = write_hit(timer_wdt_pkg::ADDR_RELOAD1);
  end

  // Both channels are identical; each has its own prescaler and counter.
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_chan
      logic tick; // Prescaler has completed a division period.
      logic clear_req; // Software writes one to the counter clear bit.
      logic [1:0] next_mode; // Mode field of the written word.

      // The counter runs only when enabled and not frozen by debug.
      always_comb
      begin
        running[i] = ctrl[i].count_enable
          && (ctrl[i].debug_hold_override || !debug_acknowledge_in);
        tick = running[i] && (presc[i] == ctrl[i].prescale);
        expire[i] = tick && (count[i] == 24'h000001);
        clear_req = write_ctrl[i] && pwdata[timer_wdt_pkg::CH_CLEAR_BIT];
        next_mode = pwdata[timer_wdt_pkg::CH_MODE_MSB:timer_wdt_pkg::CH_MODE_LSB];
      end

      // Control fields. A software write wins over the one-shot self clear,
      // so a write that restarts a channel is never undone by a stale expiry.
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          ctrl[i] <= '{
            debug_hold_override: timer_wdt_pkg::CTRL_RESET[timer_wdt_pkg::CH_OVERRIDE_BIT],
            count_enable: timer_wdt_pkg::CTRL_RESET[timer_wdt_pkg::CH_ENABLE_BIT],
            channel_irq_enable: timer_wdt_pkg::CTRL_RESET[timer_wdt_pkg::CH_IRQ_EN_BIT],
            mode: timer_wdt_pkg::CTRL_RESET[timer_wdt_pkg::CH_MODE_MSB:
                                            timer_wdt_pkg::CH_MODE_LSB],
            prescale: timer_wdt_pkg::CTRL_RESET[timer_wdt_pkg::CH_PRESCALE_MSB:0]
          };
        end
        else if (write_ctrl[i])
        begin
          ctrl[i].debug_hold_override <= pwdata[timer_wdt_pkg::CH_OVERRIDE_BIT];
          // Counter clear forces the enable low whatever else is written.
          ctrl[i].count_enable <= pwdata[timer_wdt_pkg::CH_ENABLE_BIT]
            && !clear_req;
          ctrl[i].channel_irq_enable <= pwdata[timer_wdt_pkg::CH_IRQ_EN_BIT];
          ctrl[i].mode <= next_mode;
          ctrl[i].prescale <= pwdata[timer_wdt_pkg::CH_PRESCALE_MSB:0];
        end
        else if (expire[i] && (ctrl[i].mode == timer_wdt_pkg::MODE_ONE_SHOT))
        begin
          // One-shot: stop after the single expiry.
          ctrl[i].count_enable <= 1'b0;
        end
      end

      // Prescale counter: counts clocks from zero up to the prescale value.
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          presc[i] <= 8'h00;
        else if (clear_req || write_reload[i])
          presc[i] <= 8'h00;
        else if (tick)
          presc[i] <= 8'h00;
        else if (running[i])
          presc[i] <= presc[i] + 8'h01;
      end

      // Initial count register.
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          initial_count[i] <= 24'h000000;
        else if (write_reload[i])
          initial_count[i] <= pwdata[timer_wdt_pkg::COUNT_MSB:0];
      end

      // Down counter. A zero count (after reset or clear) reloads on the
      // next tick without an expiry, so a fresh enable starts a full period.
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          count[i] <= 24'h000000;
        else if (clear_req)
          count[i] <= 24'h000000;
        else if (write_reload[i])
          count[i] <= pwdata[timer_wdt_pkg::COUNT_MSB:0];
        else if (tick)
        begin
          if (count[i] <= 24'h000001)
            count[i] <= initial_count[i];
          else
            count[i] <= count[i] - 24'h000001;
        end
      end

      // Interrupt flag: an expiry in the clearing cycle keeps the flag set.
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          flag[i] <= 1'b0;
        else if (expire[i])
          flag[i] <= 1'b1;
        else if (write_flags && pwdata[i])
          flag[i] <= 1'b0;
      end

      // Registered interrupt and square-wave outputs. The reserved mode
      // behaves as periodic, which is the harmless reading.
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          timer_irq[i] <= 1'b0;
          timer_out[i] <= 1'b0;
        end
        else
        begin
          timer_irq[i] <= (flag[i] || expire[i]) && ctrl[i].channel_irq_enable;
          if (expire[i] && (ctrl[i].mode == timer_wdt_pkg::MODE_TOGGLE))
            timer_out[i] <= !timer_out[i];
        end
      end
    end
  endgenerate

  // Watchdog state.
  timer_wdt_pkg::wd_ctrl_type wd; // Watchdog settings.
  logic xtal_q; // Previous crystal level, for edge detection.
  logic [7:0] wd_div; // Divide-by-256 prescaler.
  logic [25:0] wd_cnt; // Up counter, split in two halves in test mode.
  logic [25:0] wd_limit; // Last count before the selected timeout.
  logic [9:0] wd_delay; // Watchdog clocks since timeout.
  logic wd_timed_out; // Timeout passed, reset pending.
  logic wd_irq_flag; // Sticky watchdog interrupt flag.
  logic wd_reset_flag; // Sticky watchdog reset flag.
  logic wd_step; // Crystal edge while counting is allowed.
  logic wd_tick; // One watchdog clock.
  logic wd_restart; // Software restart request.
  logic wd_timeout; // Timeout reached this tick.
  logic wd_overflow; // A test-mode half wraps this tick.
  logic wd_fire; // Reset delay has run out.

  // Watchdog clock and event decode.
  always_comb
  begin
    wd_step = xtal_in && !xtal_q && wd.wd_enable
      && (wd.debug_hold_override || !debug_acknowledge_in);
    // Test mode ignores the divider to keep test time short.
    wd_tick = wd_step && (wd.wd_test_mode || !wd.wd_clock_divide
      || (wd_div == timer_wdt_pkg::WD_DIVIDE_LAST));
    case (wd.wd_interval_select)
      2'h0: wd_limit = timer_wdt_pkg::WD_LIMIT_SEL0;
      2'h1: wd_limit = timer_wdt_pkg::WD_LIMIT_SEL1;
      2'h2: wd_limit = timer_wdt_pkg::WD_LIMIT_SEL2;
      default: wd_limit = timer_wdt_pkg::WD_LIMIT_SEL3;
    endcase
    wd_restart = write_wd && pwdata[timer_wdt_pkg::WD_RESTART_BIT];
    wd_timeout = wd_tick && !wd.wd_test_mode && !wd_timed_out
      && (wd_cnt == wd_limit);
    wd_overflow = wd_tick && wd.wd_test_mode
      && ((&wd_cnt[timer_wdt_pkg::WD_HALF - 1:0])
      || (&wd_cnt[timer_wdt_pkg::WD_WIDTH - 1:timer_wdt_pkg::WD_HALF]));
    wd_fire = wd_tick && wd_timed_out && wd.wd_reset_enable
      && (wd_delay == timer_wdt_pkg::WD_RESET_DELAY_LAST);
  end

  // Watchdog control register; restart is a strobe and is not stored.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wd <= '{
        wd_clock_divide: timer_wdt_pkg::WD_CTRL_RESET[timer_wdt_pkg::WD_DIVIDE_BIT],
        debug_hold_override: timer_wdt_pkg::WD_CTRL_RESET[timer_wdt_pkg::WD_OVERRIDE_BIT],
        wd_test_mode: timer_wdt_pkg::WD_CTRL_RESET[timer_wdt_pkg::WD_TEST_BIT],
        wd_enable: timer_wdt_pkg::WD_CTRL_RESET[timer_wdt_pkg::WD_ENABLE_BIT],
        wd_irq_enable: timer_wdt_pkg::WD_CTRL_RESET[timer_wdt_pkg::WD_IRQ_EN_BIT],
        wd_interval_select: timer_wdt_pkg::WD_CTRL_RESET[timer_wdt_pkg::WD_SELECT_MSB:
                                                        timer_wdt_pkg::WD_SELECT_LSB],
        wd_reset_enable: timer_wdt_pkg::WD_CTRL_RESET[timer_wdt_pkg::WD_RESET_EN_BIT]
      };
    end
    else if (write_wd)
    begin
      wd.wd_clock_divide <= pwdata[timer_wdt_pkg::WD_DIVIDE_BIT];
      wd.debug_hold_override <= pwdata[timer_wdt_pkg::WD_OVERRIDE_BIT];
      wd.wd_test_mode <= pwdata[timer_wdt_pkg::WD_TEST_BIT];
      wd.wd_enable <= pwdata[timer_wdt_pkg::WD_ENABLE_BIT];
      wd.wd_irq_enable <= pwdata[timer_wdt_pkg::WD_IRQ_EN_BIT];
      wd.wd_interval_select <= pwdata[timer_wdt_pkg::WD_SELECT_MSB:
                                      timer_wdt_pkg::WD_SELECT_LSB];
      wd.wd_reset_enable <= pwdata[timer_wdt_pkg::WD_RESET_EN_BIT];
    end
  end

  // Crystal edge detector and the divide-by-256 prescaler.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      xtal_q <= 1'b0;
      wd_div <= 8'h00;
    end
    else
    begin
      xtal_q <= xtal_in;
      if (!wd.wd_enable || wd_restart)
        wd_div <= 8'h00;
      else if (wd_step)
        wd_div <= wd_div + 8'h01;
    end
  end

  // Watchdog counter; a fired reset starts the watchdog over.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wd_cnt <= 26'h0000000;
    else if (!wd.wd_enable || wd_restart || wd_fire)
      wd_cnt <= 26'h0000000;
    else if (wd_tick && wd.wd_test_mode)
    begin
      // Two independent halves, each wrapping on its own.
      wd_cnt <= {wd_cnt[25:13] + 13'h0001, wd_cnt[12:0] + 13'h0001};
    end
    else if (wd_tick && !wd_timed_out)
      wd_cnt <= wd_cnt + 26'h0000001;
  end

  // Timeout latch and the delay from timeout to system reset.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wd_timed_out <= 1'b0;
      wd_delay <= 10'h000;
    end
    else if (!wd.wd_enable || wd_restart || wd_fire)
    begin
      wd_timed_out <= 1'b0;
      wd_delay <= 10'h000;
    end
    else if (wd_timeout)
      wd_timed_out <= 1'b1;
    else if (wd_tick && wd_timed_out && (wd_delay != timer_wdt_pkg::WD_RESET_DELAY_LAST))
      wd_delay <= wd_delay + 10'h001;
  end

  // Sticky flags: a hardware set in the clearing cycle wins.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wd_irq_flag <= 1'b0;
      wd_reset_flag <= 1'b0;
    end
    else
    begin
      if (wd_timeout || wd_overflow)
        wd_irq_flag <= 1'b1;
      else if (write_wd && pwdata[timer_wdt_pkg::WD_IRQ_FLAG_BIT])
        wd_irq_flag <= 1'b0;
      if (wd_fire)
        wd_reset_flag <= 1'b1;
      else if (write_wd && pwdata[timer_wdt_pkg::WD_RESET_FLAG_BIT])
        wd_reset_flag <= 1'b0;
    end
  end

  // Registered watchdog outputs; the system reset is a one-cycle pulse.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wd_irq <= 1'b0;
      wd_system_reset <= 1'b0;
    end
    else
    begin
      wd_irq <= wd_irq_flag && wd.wd_irq_enable;
      wd_system_reset <= wd_fire;
    end
  end

  // Read data is captured in the setup phase and held for the access
  // phase; unmapped addresses and reserved bits read as zero.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        timer_wdt_pkg::ADDR_CTRL0,
        timer_wdt_pkg::ADDR_CTRL1:
          prdata <= {ctrl[paddr[2]].debug_hold_override, ctrl[paddr[2]].count_enable,
            ctrl[paddr[2]].channel_irq_enable, ctrl[paddr[2]].mode, 1'b0,
            running[paddr[2]], 17'h00000, ctrl[paddr[2]].prescale};
        timer_wdt_pkg::ADDR_RELOAD0: prdata <= {8'h00, initial_count[0]};
        timer_wdt_pkg::ADDR_RELOAD1: prdata <= {8'h00, initial_count[1]};
        timer_wdt_pkg::ADDR_COUNT0: prdata <= {8'h00, count[0]};
        timer_wdt_pkg::ADDR_COUNT1: prdata <= {8'h00, count[1]};
        timer_wdt_pkg::ADDR_FLAGS: prdata <= {30'h00000000, flag};
        timer_wdt_pkg::ADDR_WD_CTRL:
          prdata <= {21'h000000, wd.wd_clock_divide, wd.debug_hold_override,
            wd.wd_test_mode, wd.wd_enable, wd.wd_irq_enable, wd.wd_interval_select,
            wd_irq_flag, wd_reset_flag, wd.wd_reset_enable, 1'b0};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule : dual_timer_and_watchdog

// file: verif/dual_timer_and_watchdog_assertions.sv
/*
  Port-level assertions for the dual timer and watchdog block.
  Assumes it is bound to the top module and sees only its ports.
*/
module timer_wdt_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Side inputs and outputs.
  input wire logic debug_acknowledge_in,
  input wire logic xtal_in,
  input wire logic [1:0] timer_irq,
  input wire logic [1:0] timer_out,
  input wire logic wd_irq,
  input wire logic wd_system_reset
);
  default clocking main_cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // High in the cycle whose edge stores a register write.
  logic wr_now;
  assign wr_now = psel && penable && pwrite;
  // Setup phase of a read of one address.
  sequence rd_setup(logic [31:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  // No write now or a cycle ago, since registered levels lag a write by one.
  sequence no_write;
    !wr_now && !$past(wr_now);
  endsequence
  AST_TIRQ0_HELD: assert property (timer_irq[0] ##0 no_write |=> timer_irq[0])
    else $error("timer_irq[0] fell without a write");
  AST_TIRQ1_HELD: assert property (timer_irq[1] ##0 no_write |=> timer_irq[1])
    else $error("timer_irq[1] fell without a write");
  AST_WDIRQ_HELD: assert property (wd_irq ##0 no_write |=> wd_irq)
    else $error("wd_irq fell without a write");
  AST_WD_RESET_PULSE: assert property (wd_system_reset |=> !wd_system_reset)
    else $error("wd_system_reset longer than one cycle");
  AST_READ_STANDS: assert property (psel && penable && !pwrite |=> $stable(prdata))
    else $error("prdata moved after a read");
  AST_QUIET_AFTER_RESET: assert property (
    $rose(resetn) |=> timer_irq == 2'h0 && !wd_irq && !wd_system_reset)
    else $error("output up right after reset");
  AST_COUNT_RSVD: assert property (
    rd_setup(timer_wdt_pkg::ADDR_COUNT1) |=> prdata[31:24] == 8'h00)
    else $error("count upper byte not zero");
  AST_FLAGS_RSVD: assert property (
    rd_setup(timer_wdt_pkg::ADDR_FLAGS) |=> prdata[31:2] == 30'h0)
    else $error("flags reserved bits not zero");
  AST_WD_RSVD: assert property (
    rd_setup(timer_wdt_pkg::ADDR_WD_CTRL) |=> prdata[31:11] == 21'h0 && !prdata[0])
    else $error("watchdog reserved or restart bit not zero");
  AST_CTRL_RSVD: assert property (
    rd_setup(timer_wdt_pkg::ADDR_CTRL0) |=> prdata[24:8] == 17'h0)
    else $error("control reserved bits not zero");
endmodule : timer_wdt_checker

// file: verif/dual_timer_and_watchdog_tb.sv
/*
  Self-checking bench for the dual timer and watchdog block.
  Assumes the package, the design and the checker are compiled first.
*/
`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("MISMATCH %s exp %0h got %0h", what, exp, got); \
    end \
  end

module dual_timer_and_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus, all driven at the rising edge.
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic debug_acknowledge_in = 1'b0;
  logic xtal_in = 1'b0;
  logic xtal_run = 1'b0;
  // Observed outputs.
  logic [31:0] prdata;
  logic [1:0] timer_irq;
  logic [1:0] timer_out;
  logic wd_irq;
  logic wd_system_reset;
  wire logic [3:0] evt = {wd_system_reset, wd_irq, timer_irq};
  // Scoreboard state.
  int errors = 0;
  int n_compared = 0;
  int rises = 0;
  int mark;
  logic [31:0] rv;

  always #10 clk = ~clk;

  // The crystal stands low when idle and gives one rising edge per two clocks.
  always @(posedge clk)
  begin
    xtal_in <= xtal_run & ~xtal_in;
    if (xtal_run && !xtal_in)
      rises <= rises + 1;
  end

  dual_timer_and_watchdog dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .debug_acknowledge_in(debug_acknowledge_in), .xtal_in(xtal_in),
    .timer_irq(timer_irq), .timer_out(timer_out), .wd_irq(wd_irq),
    .wd_system_reset(wd_system_reset)
  );

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // One two-cycle transfer; read data is taken at the access edge.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Waits a bounded time for one output event; a miss ends the run.
  task automatic wait_hi(input int i, input int lim);
    int n = 0;
    while (evt[i] !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim)
    begin
      errors++;
      $display("MISMATCH wait event %0d exp 1 got 0", i);
      end_sim();
    end
  endtask : wait_hi

  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    // Reset values of all registers and one unmapped word.
    for (int i = 0; i < 9; i++)
    begin
      xfer(1'b0, timer_wdt_pkg::ADDR_CTRL0 + 32'(4 * i), 32'h0);
      `CHK("reset value", (i < 2) ? timer_wdt_pkg::CTRL_RESET :
        (i == 7) ? timer_wdt_pkg::WD_CTRL_RESET : 32'h0, rv)
    end
    // Divide by four: five ticks land before the stop write 22 clocks on.
    xfer(1'b1, timer_wdt_pkg::ADDR_CTRL0, 32'h40000003);
    xfer(1'b1, timer_wdt_pkg::ADDR_RELOAD0, 32'h64);
    xfer(1'b0, timer_wdt_pkg::ADDR_CTRL0, 32'h0);
    `CHK("active", 32'h42000003, rv)
    repeat (16) @(posedge clk);
    xfer(1'b1, timer_wdt_pkg::ADDR_CTRL0, 32'h00000003);
    repeat (8) @(posedge clk);
    xfer(1'b0, timer_wdt_pkg::ADDR_COUNT0, 32'h0);
    `CHK("count", 32'h5f, rv)
    xfer(1'b0, timer_wdt_pkg::ADDR_CTRL0, 32'h0);
    `CHK("stopped", 32'h00000003, rv)
    // Debug hold freezes the count until the override is set.
    debug_acknowledge_in <= 1'b1;
    xfer(1'b1, timer_wdt_pkg::ADDR_CTRL0, 32'h40000000);
    xfer(1'b1, timer_wdt_pkg::ADDR_RELOAD0, 32'h32);
    repeat (10) @(posedge clk);
    xfer(1'b0, timer_wdt_pkg::ADDR_COUNT0, 32'h0);
    `CHK("held count", 32'h32, rv)
    xfer(1'b0, timer_wdt_pkg::ADDR_CTRL0, 32'h0);
    `CHK("held status", 32'h40000000, rv)
    xfer(1'b1, timer_wdt_pkg::ADDR_CTRL0, 32'hc0000000);
    repeat (5) @(posedge clk);
    xfer(1'b0, timer_wdt_pkg::ADDR_COUNT0, 32'h0);
    `CHK("override runs", 1'b1, rv < 32'h32)
    // Counter clear, then a write to the read-only count.
    xfer(1'b1, timer_wdt_pkg::ADDR_CTRL0, 32'h44000000);
    xfer(1'b1, timer_wdt_pkg::ADDR_COUNT0, 32'h00ffffff);
    xfer(1'b0, timer_wdt_pkg::ADDR_COUNT0, 32'h0);
    `CHK("cleared count", 32'h0, rv)
    xfer(1'b0, timer_wdt_pkg::ADDR_CTRL0, 32'h0);
    `CHK("cleared enable", 1'b0, rv[30])
    debug_acknowledge_in <= 1'b0;
    // Channel zero expiry and its write-one clear.
    xfer(1'b1, timer_wdt_pkg::ADDR_RELOAD0, 32'h3);
    xfer(1'b1, timer_wdt_pkg::ADDR_CTRL0, 32'h60000000);
    wait_hi(0, 100);
    xfer(1'b1, timer_wdt_pkg::ADDR_FLAGS, 32'h1);
    xfer(1'b0, timer_wdt_pkg::ADDR_FLAGS, 32'h0);
    `CHK("flag0 cleared", 32'h0, rv)
    // Every mode on channel one, with a 40-clock period.
    for (int m = 0; m < 3; m++)
    begin
      xfer(1'b1, timer_wdt_pkg::ADDR_RELOAD1, 32'h28);
      xfer(1'b1, timer_wdt_pkg::ADDR_CTRL1, 32'h60000000 | (32'(m) << 27));
      wait_hi(1, 200);
      `CHK("toggle out", {m == 2, 1'b0}, timer_out)
      xfer(1'b1, timer_wdt_pkg::ADDR_FLAGS, 32'h0);
      xfer(1'b0, timer_wdt_pkg::ADDR_FLAGS, 32'h0);
      `CHK("flag1", 32'h2, rv)
      xfer(1'b1, timer_wdt_pkg::ADDR_FLAGS, 32'h2);
      xfer(1'b0, timer_wdt_pkg::ADDR_FLAGS, 32'h0);
      `CHK("flag1 cleared", 32'h0, rv)
      xfer(1'b0, timer_wdt_pkg::ADDR_CTRL1, 32'h0);
      `CHK("enable after expiry", (m != 0), rv[30])
      xfer(1'b1, timer_wdt_pkg::ADDR_CTRL1, 32'h04000000);
    end
    // Watchdog at the shortest interval with interrupt and reset enabled.
    xtal_run <= 1'b1;
    xfer(1'b1, timer_wdt_pkg::ADDR_WD_CTRL, 32'h000000c2);
    mark = rises;
    wait_hi(2, 40000);
    `CHK("timeout edges", 1'b1, (rises - mark) inside {[16382:16388]})
    mark = rises;
    wait_hi(3, 2000);
    `CHK("reset delay", 1'b1, (rises - mark) inside {[510:514]})
    xfer(1'b0, timer_wdt_pkg::ADDR_WD_CTRL, 32'h0);
    `CHK("watchdog flags", 32'h000000ce, rv)
    xfer(1'b1, timer_wdt_pkg::ADDR_WD_CTRL, 32'h0000000c);
    xfer(1'b0, timer_wdt_pkg::ADDR_WD_CTRL, 32'h0);
    `CHK("flags cleared", 32'h0, rv)
    // A restart about three quarters through must push the next timeout past its old time.
    xfer(1'b1, timer_wdt_pkg::ADDR_WD_CTRL, 32'h000000c2);
    repeat (24000) @(posedge clk);
    xfer(1'b1, timer_wdt_pkg::ADDR_WD_CTRL, 32'h000000c3);
    repeat (16000) @(posedge clk);
    #1;
    `CHK("no timeout after restart", 1'b0, wd_irq)
    // Test mode splits the counter and ignores the divider, so the low half wraps soon.
    xfer(1'b1, timer_wdt_pkg::ADDR_WD_CTRL, 32'h000005c0);
    wait_hi(2, 1000);
    end_sim();
  end
endmodule : dual_timer_and_watchdog_tb

bind dual_timer_and_watchdog timer_wdt_checker checker_inst (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .debug_acknowledge_in(debug_acknowledge_in), .xtal_in(xtal_in),
  .timer_irq(timer_irq), .timer_out(timer_out), .wd_irq(wd_irq),
  .wd_system_reset(wd_system_reset)
);
